// ---- hw/eeprom_pkg.sv ----
// package: constants and types for the serial eeprom command engine
// Notes on behaviour
// - status read command is accepted at any time, even while a write runs
// - busy flag is read-only: 1 while an internal write runs, else 0
// - latch flag read-only, untouched by status write; latch 0 blocks all writes
// - protect code 00 none, 01 upper quarter, 10 upper half, 11 whole array
// - protect bits are non-volatile and change only through status write; reset here reloads them with 00
// - protect bits read frozen during a write; busy and latch update live
// - status write commits only if select rises exactly after the 16th clock
// - delivered state of both protect bits is 00, nothing protected
// - read sends instruction then address byte msb first; ninth bit is b3
// - read shifts out on falling edges, increments, wraps to zero until deselect
// - only the address bits of the density are used, higher bits ignored
// - array read arriving during a write is rejected until next select
// - deselect right after a data byte starts the write, otherwise cancelled
// - busy reads 1 during the write, then 0 and the latch is cleared
// - page write takes up to 16 bytes in one page in one write time
// - page address wraps from last to first location of the same page
// - non-volatile write starts only if select rises on a multiple of 8 clocks
// - array commands are ignored while programming; programming runs on
// - after latch set, latch clear or status read, wait for deselect
// - select and hold transitions at invalid points are ignored
// - power-on: deselected, no hold, latch clear; needs select fall first
// - instruction byte decode of the six command codes
// - undefined instruction deselects the device for the rest of the frame
// - write-protect pin low rejects writes, clears latch, never aborts a write
// - hold low pauses transfer, floats output, ignores data and clock
package eeprom_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_TIME_NS = 5000000;
    localparam int WRITE_CYCLES_DEF = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W_DEF = 24;
    localparam int ADDR_W_DEF = 9;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int CMD_A8_BIT = 3;

    localparam logic [3:0] CMD_TOP = 4'h0;
    localparam logic [2:0] OP_LATCH_SET = 3'h6;
    localparam logic [2:0] OP_LATCH_CLR = 3'h4;
    localparam logic [2:0] OP_STAT_RD = 3'h5;
    localparam logic [2:0] OP_STAT_WR = 3'h1;
    localparam logic [2:0] OP_ARR_RD = 3'h3;
    localparam logic [2:0] OP_ARR_WR = 3'h2;

    localparam int SB_BP_LO = 2;
    localparam int SB_BP_HI = 3;
    localparam logic [3:0] STATUS_RO_TOP = 4'hf;
    localparam logic [1:0] BP_DELIVERY = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] BYTES_STATUS = 2'h2;
    localparam logic [1:0] BYTES_DATA = 2'h3;

    typedef enum logic [2:0] {
        CMD_LATCH_SET, CMD_LATCH_CLR, CMD_STAT_RD, CMD_STAT_WR,
        CMD_ARR_RD, CMD_ARR_WR, CMD_BAD
    } cmd_e;

    typedef enum logic [3:0] {
        PH_CMD, PH_RD_ADDR, PH_WR_ADDR, PH_DATA, PH_READ,
        PH_SR_DATA, PH_STAT_OUT, PH_WAIT, PH_IGNORE
    } phase_e;

    typedef enum logic [1:0] {WK_NONE, WK_ARRAY, WK_STATUS} wr_kind_e;

    // instruction byte to command
    function automatic cmd_e decode_cmd(input logic [7:0] b);
        decode_cmd = CMD_BAD;
        if (b[7:4] == CMD_TOP) begin
            case (b[2:0])
                OP_LATCH_SET: decode_cmd = CMD_LATCH_SET;
                OP_LATCH_CLR: decode_cmd = CMD_LATCH_CLR;
                OP_STAT_RD:   decode_cmd = CMD_STAT_RD;
                OP_STAT_WR:   decode_cmd = CMD_STAT_WR;
                OP_ARR_RD:    decode_cmd = CMD_ARR_RD;
                OP_ARR_WR:    decode_cmd = CMD_ARR_WR;
                default:      decode_cmd = CMD_BAD;
            endcase
        end
    endfunction

endpackage

// ---- hw/write_cycle_ctrl.sv ----
// write cycle controller: latch, protect bits, busy timer and commit
`timescale 1ns/1ps
`default_nettype none
module write_cycle_ctrl import eeprom_pkg::*; #(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
    parameter int TIMER_W      = TIMER_W_DEF
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       cs_n,
    input  wire logic       wp_n,
    input  wire logic       set_tgl,
    input  wire logic       clr_tgl,
    input  wire logic       commit_ok,
    input  wire logic       is_status,
    input  wire logic [1:0] sr_bp,
    output logic            busy,
    output logic            write_latch_flag,
    output logic [1:0]      bp,
    output logic            armed,
    output logic            mem_we
);

    typedef struct packed {
        logic [3:0]         s1;
        logic [3:0]         s2;
        logic [2:0]         prev;
        logic               busy;
        logic               write_latch_flag;
        logic [1:0]         bp;
        logic [1:0]         bp_pend;
        logic               is_stat;
        logic               armed;
        logic               mem_we;
        logic [TIMER_W-1:0] timer;
    } ctrl_s;

    ctrl_s r;
    ctrl_s n;
    logic  cs_rise;
    logic  set_ev;
    logic  clr_ev;
    logic  wp_ok;

    // events seen through the two-flop synchronisers
    assign cs_rise = r.s2[3] && !r.prev[2];
    assign set_ev  = r.s2[1] != r.prev[1];
    assign clr_ev  = r.s2[0] != r.prev[0];
    assign wp_ok   = r.s2[2];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n = r;
        n.s1 = {cs_n, wp_n, set_tgl, clr_tgl};
        n.s2 = r.s1;
        n.prev = {r.s2[3], r.s2[1], r.s2[0]};
        n.mem_we = 1'b0;
        if (r.s2[3]) begin
            n.armed = 1'b1;
        end
        if (r.busy) begin
            if (r.timer == TIMER_W'(1)) begin
                n.busy = 1'b0;
                n.write_latch_flag = 1'b0;
                if (r.is_stat) begin
                    n.bp = r.bp_pend;
                end
            end else begin
                n.timer = r.timer - TIMER_W'(1);
            end
        end else if (cs_rise && commit_ok && r.write_latch_flag && wp_ok) begin
            n.busy = 1'b1;
            n.timer = TIMER_W'(WRITE_CYCLES);
            n.is_stat = is_status;
            n.bp_pend = sr_bp;
            n.mem_we = !is_status;
        end
        // a latch command seen with completion still sets the latch
        if (set_ev) begin
            n.write_latch_flag = 1'b1;
        end
        if (clr_ev) begin
            n.write_latch_flag = 1'b0;
        end
        if (!wp_ok) begin
            n.write_latch_flag = 1'b0;
        end
    end

    // state register, delivery protect value after reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{s1: 4'h0, s2: 4'h0, prev: 3'h0, busy: 1'b0, write_latch_flag: 1'b0,
                   bp: BP_DELIVERY, bp_pend: BP_DELIVERY, is_stat: 1'b0,
                   armed: 1'b0, mem_we: 1'b0, timer: '0};
        end else begin
            r <= n;
        end
    end

    assign busy   = r.busy;
    assign write_latch_flag    = r.write_latch_flag;
    assign bp     = r.bp;
    assign armed  = r.armed;
    assign mem_we = r.mem_we;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence commit_s;
        !r.busy && cs_rise && commit_ok && r.write_latch_flag && wp_ok;
    endsequence

    sequence finish_s;
        r.busy && r.timer == TIMER_W'(1) && !set_ev;
    endsequence

    AST_COMMIT_STARTS:
    assert property (@(posedge clk) disable iff (reset)
        commit_s |=> r.busy && r.timer == TIMER_W'(WRITE_CYCLES))
        else $error("write cycle did not start on valid deselect");
    AST_NO_LATCH_NO_WRITE:
    assert property (@(posedge clk) disable iff (reset)
        (!r.busy && cs_rise && !r.write_latch_flag) |=> !r.busy && !r.mem_we)
        else $error("write started with latch clear");
    AST_DONE_CLEARS:
    assert property (@(posedge clk) disable iff (reset)
        finish_s |=> !r.busy && !r.write_latch_flag)
        else $error("busy or latch not cleared at end of write");
    AST_BP_FROZEN:
    assert property (@(posedge clk) disable iff (reset)
        (r.busy && $past(r.busy)) |-> $stable(r.bp))
        else $error("protect bits moved during a write");
    AST_WP_CLEARS:
    assert property (@(posedge clk) disable iff (reset)
        !wp_ok |=> !r.write_latch_flag)
        else $error("latch not cleared while protect pin low");
    AST_BUSY_RUNS:
    assert property (@(posedge clk) disable iff (reset)
        (r.busy && r.timer > TIMER_W'(1)) |=> r.busy)
        else $error("write cycle aborted early");

endmodule
`default_nettype wire

// ---- hw/serial_eeprom_command_engine.sv ----
// serial eeprom command engine: serial link decoder, array and outputs
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_engine import eeprom_pkg::*; #(
    parameter int ADDR_W       = ADDR_W_DEF,
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so,
    output logic      so_oe_n
);

    localparam int MEM_BYTES = 1 << ADDR_W;

    ////////////////////////////////////////////////////////////////////////
    // link state, clocked by the serial clock
    typedef struct packed {
        phase_e                     phase;
        wr_kind_e                   kind;
        logic [2:0]                 bit_idx;
        logic [1:0]                 byte_cnt;
        logic [6:0]                 shreg;
        logic                       hi_bit;
        logic [ADDR_W-1:0]          addr;
        logic [7:0]                 tx;
        logic [7:0]                 sr_data;
        logic [PAGE_BYTES-1:0]      mask;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
        logic                       set_tgl;
        logic                       clr_tgl;
        logic [4:0]                 meta1;
        logic [4:0]                 meta2;
    } link_s;

    link_s             r;
    link_s             n;
    logic [7:0]        mem [0:MEM_BYTES-1] = '{default: ERASED_BYTE};
    logic              in_frame_r;
    logic              frame_off;
    logic              first;
    logic [2:0]        bit_i;
    logic [1:0]        bcnt;
    phase_e            ph;
    wr_kind_e          kd;
    logic [7:0]        rx;
    logic [8:0]        wide_addr;
    logic [ADDR_W-1:0] full_addr;
    logic [ADDR_W-1:0] addr_inc;
    logic [PAGE_W-1:0] page_lo_inc;
    logic [7:0]        status_word;
    logic              busy_s;
    logic              armed_s;
    logic              commit_ok;
    logic              drive;
    logic              busy;
    logic              write_latch_flag;
    logic [1:0]        bp;
    logic              armed;
    logic              mem_we;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // address lies in the region chosen by the protect code
    function automatic logic is_protected(input logic [ADDR_W-1:0] a,
                                          input logic [1:0] code);
        case (code)
            BP_QUARTER: is_protected = a[ADDR_W-1] && a[ADDR_W-2];
            BP_HALF:    is_protected = a[ADDR_W-1];
            BP_ALL:     is_protected = 1'b1;
            default:    is_protected = 1'b0;
        endcase
    endfunction

    // the first rising edge after select restarts the frame counters
    assign first = !in_frame_r;
    assign bit_i = first ? BIT_FIRST : r.bit_idx;
    assign bcnt  = first ? 2'h0 : r.byte_cnt;
    assign ph    = first ? PH_CMD : r.phase;
    assign kd    = first ? WK_NONE : r.kind;
    assign rx    = {r.shreg, si};

    // address from the ninth bit and the address byte
    assign wide_addr   = {r.hi_bit, rx};
    assign full_addr   = wide_addr[ADDR_W-1:0];
    assign addr_inc    = r.addr + 1'b1;
    assign page_lo_inc = r.addr[PAGE_W-1:0] + 1'b1;

    // synchronised view of the write controller
    assign busy_s  = r.meta2[0];
    assign armed_s = r.meta2[4];

    // status byte as seen by the master
    assign status_word = {STATUS_RO_TOP, r.meta2[3:2], r.meta2[1], r.meta2[0]};

    // frame result, static once the serial clock stops after deselect
    assign commit_ok = (r.kind == WK_STATUS && r.byte_cnt == BYTES_STATUS
                        && r.bit_idx == BIT_FIRST)
                    || (r.kind == WK_ARRAY && r.phase == PH_DATA
                        && r.byte_cnt == BYTES_DATA
                        && r.bit_idx == BIT_FIRST);

    assign frame_off = cs_n || reset;
    assign drive = in_frame_r && (r.phase == PH_READ || r.phase == PH_STAT_OUT);

    ////////////////////////////////////////////////////////////////////////
    // command decoder, one step per rising serial clock edge
    always_comb begin
        n = r;
        n.meta1 = {armed, bp, write_latch_flag, busy};
        n.meta2 = r.meta1;
        if (hold_n) begin
            n.shreg = rx[6:0];
            n.bit_idx = bit_i + 3'h1;
            n.byte_cnt = bcnt;
            n.phase = ph;
            n.kind = kd;
            if (bit_i == BIT_LAST) begin
                if (bcnt != BYTES_DATA) begin
                    n.byte_cnt = bcnt + 2'h1;
                end
                case (ph)
                    PH_CMD: begin
                        n.phase = PH_IGNORE;
                        n.hi_bit = rx[CMD_A8_BIT];
                        if (armed_s) begin
                            case (decode_cmd(rx))
                                CMD_LATCH_SET: begin
                                    n.set_tgl = !r.set_tgl;
                                    n.phase = PH_WAIT;
                                end
                                CMD_LATCH_CLR: begin
                                    n.clr_tgl = !r.clr_tgl;
                                    n.phase = PH_WAIT;
                                end
                                CMD_STAT_RD: begin
                                    n.tx = status_word;
                                    n.phase = PH_STAT_OUT;
                                end
                                CMD_STAT_WR: begin
                                    n.kind = WK_STATUS;
                                    n.phase = PH_SR_DATA;
                                end
                                CMD_ARR_RD: begin
                                    if (!busy_s) begin
                                        n.phase = PH_RD_ADDR;
                                    end
                                end
                                CMD_ARR_WR: begin
                                    if (!busy_s) begin
                                        n.kind = WK_ARRAY;
                                        n.phase = PH_WR_ADDR;
                                    end
                                end
                                default: n.phase = PH_IGNORE;
                            endcase
                        end
                    end
                    PH_RD_ADDR: begin
                        n.addr = full_addr;
                        n.tx = mem[full_addr];
                        n.phase = PH_READ;
                    end
                    PH_WR_ADDR: begin
                        n.addr = full_addr;
                        n.mask = '0;
                        n.phase = PH_DATA;
                    end
                    PH_DATA: begin
                        // page buffer, later bytes overwrite earlier ones
                        n.pbuf[r.addr[PAGE_W-1:0]] = rx;
                        n.mask[r.addr[PAGE_W-1:0]] = 1'b1;
                        n.addr = {r.addr[ADDR_W-1:PAGE_W], page_lo_inc};
                    end
                    PH_READ: begin
                        n.addr = addr_inc;
                        n.tx = mem[addr_inc];
                    end
                    PH_SR_DATA: begin
                        n.sr_data = rx;
                        n.phase = PH_WAIT;
                    end
                    PH_STAT_OUT: begin
                        n.phase = PH_WAIT;
                    end
                    default: n.phase = ph;
                endcase
            end
        end
    end

    // link state register
    always_ff @(posedge sck or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // frame marker, cleared whenever the device is deselected
    always_ff @(posedge sck or posedge frame_off) begin
        if (frame_off) begin
            in_frame_r <= 1'b0;
        end else if (hold_n) begin
            in_frame_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial output on falling edges, released while deselected or held
    always_ff @(negedge sck or posedge frame_off) begin
        if (frame_off) begin
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so <= r.tx[BIT_LAST - r.bit_idx];
            so_oe_n <= !(drive && hold_n);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write controller in the system clock domain
    write_cycle_ctrl #(
        .WRITE_CYCLES (WRITE_CYCLES),
        .TIMER_W      (TIMER_W_DEF)
    ) u_ctrl (
        .clk       (clk),
        .reset     (reset),
        .cs_n      (cs_n),
        .wp_n      (wp_n),
        .set_tgl   (r.set_tgl),
        .clr_tgl   (r.clr_tgl),
        .commit_ok (commit_ok),
        .is_status (r.kind == WK_STATUS),
        .sr_bp     (r.sr_data[SB_BP_HI:SB_BP_LO]),
        .busy      (busy),
        .write_latch_flag       (write_latch_flag),
        .bp        (bp),
        .armed     (armed),
        .mem_we    (mem_we)
    );

    ////////////////////////////////////////////////////////////////////////
    // page commit, skipping bytes inside the protected region; array starts erased
    always_ff @(posedge clk) begin
        if (mem_we) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (r.mask[i] && !is_protected({r.addr[ADDR_W-1:PAGE_W],
                        PAGE_W'(i)}, bp)) begin
                    mem[{r.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= r.pbuf[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the link side
    sequence cmd_byte_s;
        in_frame_r && hold_n && r.phase == PH_CMD && r.bit_idx == BIT_LAST;
    endsequence

    AST_WAIT_STAYS:
    assert property (@(posedge sck) disable iff (reset)
        (in_frame_r && hold_n && r.phase == PH_WAIT)
        |=> (!in_frame_r || r.phase == PH_WAIT))
        else $error("wait state left without deselect");
    AST_READ_REJECT:
    assert property (@(posedge sck) disable iff (reset)
        (cmd_byte_s ##0 (decode_cmd(rx) == CMD_ARR_RD && busy_s))
        |=> r.phase == PH_IGNORE)
        else $error("array read accepted during a write");
    AST_PAGE_KEPT:
    assert property (@(posedge sck) disable iff (reset)
        (in_frame_r && hold_n && r.phase == PH_DATA && r.bit_idx == BIT_LAST)
        |=> r.addr[ADDR_W-1:PAGE_W] == $past(r.addr[ADDR_W-1:PAGE_W]))
        else $error("page write left its page");

endmodule
`default_nettype wire

// ---- bench/spi_master_model.sv ----
// spi master model driving the serial link in mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    output var logic sck,
    output var logic cs_n,
    output var logic si,
    input  wire logic so
);
    // link clock idles low between frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // one frame of n bits msb first, so captured at each rising edge
    task automatic xfer(input logic [39:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0;
        cs_n = 1'b0;
        #6;
        // 12 ns link clock period: data set while the clock is low
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            #6 sck = 1'b1;
            rx = {rx[14:0], so};
            #6 sck = 1'b0;
        end
        #6 cs_n = 1'b1;
        si = ~si; // released line shows no stale level
        #200;
    endtask
endmodule
`default_nettype wire

// ---- bench/serial_eeprom_command_engine_tb.sv ----
// self-checking bench for the serial eeprom command engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module serial_eeprom_command_engine_tb;
    import eeprom_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hold_n = 1'b1;
    logic wp_n = 1'b1;
    wire logic sck, cs_n, si, so, so_oe_n;
    int err_total = 0;
    int check_count = 0;
    logic drove;
    logic [15:0] rx;
    logic [7:0] st;
    ////////////////////////////////////////////////////////////////////////
    serial_eeprom_command_engine #(.ADDR_W(9), .WRITE_CYCLES(20)) i_dut (
        .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n));
    spi_master_model i_master (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    initial forever #20 clk = ~clk;
    // remembers whether the output was ever driven in a frame
    always @(negedge so_oe_n) drove = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic sr(output logic [7:0] s);
        i_master.xfer(40'h0500, 16, rx);
        s = rx[7:0];
    endtask
    task automatic latch();
        i_master.xfer(40'h06, 8, rx);
    endtask
    // polls busy with a bounded count
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            sr(st);
            if (st[0] === 1'b0) return;
        end
        err_total++;
        stop_test();
    endtask
    task automatic rd2(input logic [8:0] a, input logic [15:0] e);
        i_master.xfer({16'h0, 4'h0, a[8], 3'h3, a[7:0], 16'h0}, 32, rx);
        `CHK("read data", e, rx)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_latch();
        sr(st);
        `CHK("delivery status", 8'hf0, st)
        `CHK("idle output", 1'b1, so_oe_n)
        latch();
        sr(st);
        `CHK("latch set", 8'hf2, st)
        i_master.xfer(40'h04, 8, rx);
        sr(st);
        `CHK("latch clear", 8'hf0, st)
    endtask
    task automatic t_write();
        latch();
        i_master.xfer(40'h0aa53c, 24, rx);
        sr(st);
        `CHK("busy status", 8'hf3, st)
        drove = 1'b0;
        i_master.xfer(40'h0ba50000, 32, rx);
        `CHK("read rejected", 1'b0, drove)
        wait_idle();
        `CHK("after write", 8'hf0, st)
        rd2(9'h1a5, 16'h3cff);
    endtask
    task automatic t_page();
        latch();
        i_master.xfer({16'h0afe, 24'ha1a2a3}, 40, rx);
        wait_idle();
        rd2(9'h1fe, 16'ha1a2);
        rd2(9'h1ff, 16'ha2ff);
        rd2(9'h1f0, 16'ha3ff);
    endtask
    task automatic t_refuse();
        i_master.xfer(40'h0a2000, 24, rx);
        sr(st);
        `CHK("no latch write", 8'hf0, st)
        latch();
        i_master.xfer(40'h0a210, 20, rx);
        wait_idle();
        rd2(9'h120, 16'hffff);
        drove = 1'b0;
        i_master.xfer(40'h800500, 24, rx);
        `CHK("bad code", 1'b0, drove)
        latch();
        i_master.xfer(40'h010c, 16, rx);
        sr(st);
        `CHK("frozen protect", 8'hf3, st)
        wait_idle();
        `CHK("protect set", 8'hfc, st)
        latch();
        i_master.xfer(40'h021000, 24, rx);
        wait_idle();
        rd2(9'h010, 16'hffff);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        t_latch();
        t_write();
        t_page();
        t_refuse();
        stop_test();
    end
endmodule
`default_nettype wire
